// ### hw/e1osp_pkg.sv
// Constants, register map and state types for the E1 transmit overhead source selector.
// Assumes a 25 MHz pclk carrying one outbound line bit per clock and an APB master.
package e1osp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] SIGDL_IDX = 16'h010a;
  localparam logic [15:0] CTRL_IDX  = 16'h0140;
  localparam logic [15:0] STAT_IDX  = 16'h0141;

  // Link select register fields
  localparam int unsigned SA4EN_BIT = 3;
  localparam int unsigned CODE_LSB  = 0;

  // Own control register fields
  localparam int unsigned LINK_LSB   = 0;
  localparam int unsigned SASEL_BIT  = 2;
  localparam int unsigned SA4VAL_BIT = 3;
  localparam int unsigned CAS_LSB    = 4;
  localparam int unsigned TS16P_BIT  = 6;
  localparam int unsigned DEPIN_BIT  = 7;

  // Reset values
  localparam logic [3:0] SIGDL_RST = 4'h0;
  localparam logic [7:0] CTRL_RST  = 8'h00;

  // Frame positions
  localparam logic [2:0] SA4_POS  = 3'h3;
  localparam logic [4:0] TS0      = 5'h00;
  localparam logic [4:0] TS16     = 5'h10;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Source selection codes
  localparam logic [2:0] CODE_DL_SER   = 3'h0;
  localparam logic [2:0] CODE_DL_CAS   = 3'h1;
  localparam logic [2:0] CODE_ONE_SER  = 3'h2;
  localparam logic [2:0] CODE_ONE_CAS  = 3'h3;
  localparam logic [2:0] CODE_DL_SIGDE = 3'h4;
  localparam logic [1:0] LINK_HDLC     = 2'h1;

  // CAS timeslot 16 sources
  localparam logic [1:0] CAS_SERIAL = 2'h0;
  localparam logic [1:0] CAS_REG    = 2'h1;
  localparam logic [1:0] CAS_OH     = 2'h2;
  localparam logic [1:0] CAS_SIG    = 2'h3;

  typedef struct packed {
    logic [2:0] bit_pos;
    logic [4:0] slot;
    logic       frame_odd;
  } e1osp_pos_type;

  typedef struct packed {
    logic [3:0]  sigdl;
    logic [7:0]  ctrl;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        line;
    logic        take;
  } e1osp_state_type;

endpackage : e1osp_pkg

// ### hw/e1osp_position.sv
// Bit, timeslot and frame-parity counter for the outbound E1 stream.
// Assumes frame_sync pulses one clock before bit 0 of timeslot 0 of a FAS frame.
module e1osp_position
  import e1osp_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Alignment
  input  wire logic       frame_sync,
  // Position
  output logic [2:0]      bit_pos,
  output logic [4:0]      slot,
  output logic            frame_odd
);

  e1osp_pos_type s;
  e1osp_pos_type next_s;

  always_comb begin
    next_s = s;
    if (frame_sync) begin
      next_s = '0;
    end else begin
      next_s.bit_pos = s.bit_pos + 3'h1;
      if (s.bit_pos == LAST_BIT) begin
        next_s.slot = s.slot + 5'h01;
        // Slot wraps naturally at 32; frame parity flips on the wrap
        if (s.slot == 5'h1f) begin
          next_s.frame_odd = ~s.frame_odd;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bit_pos   = s.bit_pos;
  assign slot      = s.slot;
  assign frame_odd = s.frame_odd;

endmodule : e1osp_position

// ### hw/e1osp_top.sv
// Transmit overhead source selector: picks Sa4, D/E and timeslot 16 sources per bit.
// Assumes backplane inputs and data link bit are synchronous to pclk, one line bit per clock.
//
// Design decisions made here: the register offsets and the APB register port.
module e1osp_top
  import e1osp_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Frame alignment
  input  wire logic        frame_sync,
  // Backplane inputs
  input  wire logic        tx_serial_in,
  input  wire logic        tx_fraction_data_in,
  input  wire logic        tx_signaling_in,
  input  wire logic        tx_overhead_in,
  input  wire logic        de_active,
  // Per-timeslot signaling register bit for the current position
  input  wire logic        ts_sig_reg_bit,
  // Data link source
  input  wire logic        dl_bit_in,
  output logic             dl_bit_take,
  // Outbound stream
  output logic             tx_line_out
);

  e1osp_state_type s;
  e1osp_state_type next_s;

  logic [2:0] bit_pos;
  logic [4:0] slot;
  logic       frame_odd;

  e1osp_position u_position (
    .pclk       (pclk),
    .presetn    (presetn),
    .frame_sync (frame_sync),
    .bit_pos    (bit_pos),
    .slot       (slot),
    .frame_odd  (frame_odd)
  );

  // Unused codes fall back to the default selection
  function automatic logic [2:0] eff_code(input logic [2:0] raw);
    return (raw > CODE_DL_SIGDE) ? CODE_DL_SER : raw;
  endfunction : eff_code

  // Word index from a byte address; misaligned addresses miss every register
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
    return (addr[1:0] == 2'h0) && (addr[15:2] == idx[13:0]);
  endfunction : hit

  logic [2:0] code;
  logic       sa4_en;
  logic [1:0] link_sel;
  logic       sa_sel;
  logic       sa4_val;
  logic [1:0] cas_sel;
  logic       ts16_pin;
  logic       de_pin;
  logic       nat_ones;
  logic       sa4_slot;
  logic       dl_ok;
  logic       in_ts16;
  logic       setup;
  logic       mapped;
  logic [31:0] rd_word;
  logic       line_bit;
  logic       take_bit;

  always_comb begin
    code     = eff_code(s.sigdl[CODE_LSB +: 3]);
    sa4_en   = s.sigdl[SA4EN_BIT];
    link_sel = s.ctrl[LINK_LSB +: 2];
    sa_sel   = s.ctrl[SASEL_BIT];
    sa4_val  = s.ctrl[SA4VAL_BIT];
    cas_sel  = s.ctrl[CAS_LSB +: 2];
    ts16_pin = s.ctrl[TS16P_BIT];
    de_pin   = s.ctrl[DEPIN_BIT];
    nat_ones = (code == CODE_ONE_SER) || (code == CODE_ONE_CAS);
    sa4_slot = (slot == TS0) && frame_odd && (bit_pos == SA4_POS);
    dl_ok    = sa4_en && (link_sel == LINK_HDLC) && !sa_sel;
    in_ts16  = (slot == TS16);
  end

  // Bit source selection
  always_comb begin
    line_bit = tx_serial_in;
    take_bit = 1'b0;
    if (sa4_slot) begin
      if (nat_ones) begin
        line_bit = 1'b1;
      end else if (sa_sel) begin
        line_bit = sa4_val;
      end else if (!sa4_en) begin
        line_bit = 1'b1;
      end else if (dl_ok) begin
        line_bit = dl_bit_in;
        take_bit = 1'b1;
      end else begin
        // Enabled but no HDLC source: serial passes through
        line_bit = tx_serial_in;
      end
    end else if (in_ts16) begin
      unique case (code)
        CODE_DL_CAS, CODE_ONE_CAS: begin
          unique case (cas_sel)
            CAS_SERIAL: line_bit = tx_serial_in;
            CAS_REG:    line_bit = ts_sig_reg_bit;
            CAS_OH:     line_bit = tx_overhead_in;
            CAS_SIG:    line_bit = tx_signaling_in;
          endcase
        end
        CODE_ONE_SER: line_bit = ts16_pin ? tx_signaling_in : tx_serial_in;
        default:      line_bit = tx_serial_in;
      endcase
    end else if (de_active && (slot != TS0)) begin
      if (code == CODE_DL_SIGDE) begin
        line_bit = de_pin ? tx_signaling_in : tx_serial_in;
      end else begin
        line_bit = de_pin ? tx_fraction_data_in : tx_serial_in;
      end
    end
  end

  // Register read mux, captured in the setup cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    if (hit(paddr, SIGDL_IDX)) begin
      rd_word[3:0] = s.sigdl;
    end else if (hit(paddr, CTRL_IDX)) begin
      rd_word[7:0] = s.ctrl;
    end else if (hit(paddr, STAT_IDX)) begin
      rd_word[8:0]   = {frame_odd, slot, bit_pos};
      rd_word[11:9]  = code;
      rd_word[12]    = dl_ok;
    end else begin
      mapped = 1'b0;
    end
  end

  assign setup = psel && !penable;

  always_comb begin
    next_s      = s;
    next_s.line = line_bit;
    next_s.take = take_bit;
    // Zero-wait answer: pready rises in the access cycle and drops after it
    next_s.pready  = setup;
    next_s.pslverr = setup && !mapped;
    if (setup) begin
      next_s.prdata = pwrite ? 32'h0000_0000 : rd_word;
    end
    if (psel && penable && s.pready && pwrite && !s.pslverr && pstrb[0]) begin
      if (hit(paddr, SIGDL_IDX)) begin
        // Sa5-Sa8 enables are not implemented and read back as zero
        next_s.sigdl = pwdata[3:0];
      end else if (hit(paddr, CTRL_IDX)) begin
        next_s.ctrl = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s       <= '0;
      s.sigdl <= SIGDL_RST;
      s.ctrl  <= CTRL_RST;
      s.line  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign pready      = s.pready;
  assign pslverr     = s.pslverr;
  assign prdata      = s.prdata;
  assign tx_line_out = s.line;
  assign dl_bit_take = s.take;

  sa4_off_ones_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    sa4_slot && !nat_ones && !sa_sel && !sa4_en |=> tx_line_out
  ) else $error("Sa4 not forced to one with link disabled");

  sa4_link_data_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    sa4_slot && !nat_ones && dl_ok |=> dl_bit_take && (tx_line_out == $past(dl_bit_in))
  ) else $error("Sa4 did not carry the data link bit");

  take_cause_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    dl_bit_take |-> $past(sa4_slot && sa4_en && link_sel == LINK_HDLC && !sa_sel)
  ) else $error("Data link bit taken outside an enabled Sa4 position");

  sa4_reg_src_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    sa4_slot && !nat_ones && sa_sel |=> !dl_bit_take && (tx_line_out == $past(sa4_val))
  ) else $error("Sa4 register value not sent");

  nat_ones_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    sa4_slot && (s.sigdl[2:0] == CODE_ONE_SER || s.sigdl[2:0] == CODE_ONE_CAS)
      |=> tx_line_out && !dl_bit_take
  ) else $error("National bit not forced to one");

  cas_oh_src_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    in_ts16 && (s.sigdl[2:0] == CODE_DL_CAS) && (cas_sel == CAS_OH)
      |=> tx_line_out == $past(tx_overhead_in)
  ) else $error("Timeslot 16 not taken from overhead pin");

  ts16_serial_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    in_ts16 && (s.sigdl[2:0] == CODE_DL_SER || s.sigdl[2:0] == CODE_DL_SIGDE)
      |=> tx_line_out == $past(tx_serial_in)
  ) else $error("Timeslot 16 not taken from serial pin");

  de_sig_src_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    de_active && !in_ts16 && (slot != TS0) && (s.sigdl[2:0] == CODE_DL_SIGDE) && de_pin
      |=> tx_line_out == $past(tx_signaling_in)
  ) else $error("D/E channel not taken from signaling pin");

  bad_code_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    in_ts16 && (s.sigdl[2:0] > CODE_DL_SIGDE) |=> tx_line_out == $past(tx_serial_in)
  ) else $error("Unused code not handled as default");

  reset_zero_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (s.sigdl == SIGDL_RST) && (code == CODE_DL_SER)
  ) else $error("Link select register not zero after reset");

  apb_answer_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready
  ) else $error("APB answer not in the access cycle");

  apb_slverr_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> pready && pslverr
  ) else $error("Unmapped access answered without error");

  sa4_pass_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    sa4_slot && !nat_ones && !sa_sel && sa4_en && (link_sel != LINK_HDLC)
      |=> !dl_bit_take && (tx_line_out == $past(tx_serial_in))
  ) else $error("Sa4 serial value not passed through");

  cas_ser_src_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    in_ts16 && (code == CODE_DL_CAS || code == CODE_ONE_CAS) && (cas_sel == CAS_SERIAL)
      |=> tx_line_out == $past(tx_serial_in)
  ) else $error("Timeslot 16 not taken from serial pin under CAS");

  cas_reg_src_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    in_ts16 && (code == CODE_DL_CAS || code == CODE_ONE_CAS) && (cas_sel == CAS_REG)
      |=> tx_line_out == $past(ts_sig_reg_bit)
  ) else $error("Timeslot 16 not taken from signaling register");

  cas_sig_src_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    in_ts16 && (code == CODE_DL_CAS || code == CODE_ONE_CAS) && (cas_sel == CAS_SIG)
      |=> tx_line_out == $past(tx_signaling_in)
  ) else $error("Timeslot 16 not taken from signaling pin under CAS");

  ts16_sig_pin_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    in_ts16 && (s.sigdl[2:0] == CODE_ONE_SER) && ts16_pin
      |=> tx_line_out == $past(tx_signaling_in)
  ) else $error("Timeslot 16 not taken from signaling pin under code 010");

  de_frac_src_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    de_active && !in_ts16 && (slot != TS0) && (s.sigdl[2:0] != CODE_DL_SIGDE) && de_pin
      |=> tx_line_out == $past(tx_fraction_data_in)
  ) else $error("D/E channel not taken from fraction pin");

  de_serial_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    de_active && !in_ts16 && (slot != TS0) && !de_pin
      |=> tx_line_out == $past(tx_serial_in)
  ) else $error("D/E channel not taken from serial pin");

endmodule : e1osp_top

// ### test/e1osp_backplane.sv
// Backplane model: drives the four transmit input pins from levels chosen by the bench.
// Assumes pclk from the bench; pins change only just after a rising edge.
module e1osp_backplane (
  // Clock
  input  wire logic       pclk,
  // Wanted levels: overhead, signaling, fraction, serial
  input  wire logic [3:0] lvl,
  // Pins
  output logic            tx_serial_in,
  output logic            tx_fraction_data_in,
  output logic            tx_signaling_in,
  output logic            tx_overhead_in
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk) begin
    {tx_overhead_in, tx_signaling_in, tx_fraction_data_in, tx_serial_in} <= lvl;
  end
endmodule : e1osp_backplane

// ### test/tb_e1_tx_overhead_source_select.sv
// Self-checking bench for the overhead source selector.
// Assumes the one-clock stream lag of the top module; APB calls wait for pready.
module tb_e1_tx_overhead_source_select;
  import e1osp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] lvl;
  logic frame_sync, de_active, ts_sig_reg_bit, dl_bit_in, dl_bit_take, tx_line_out;
  logic ser, frac, sig, ovh, err;
  int fail_count, n_checks;
  localparam logic [15:0] LINK_A = {SIGDL_IDX[13:0], 2'h0};
  localparam logic [15:0] CTRL_A = {CTRL_IDX[13:0], 2'h0};

  e1osp_top u_e1osp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .frame_sync(frame_sync), .tx_serial_in(ser),
    .tx_fraction_data_in(frac), .tx_signaling_in(sig), .tx_overhead_in(ovh),
    .de_active(de_active), .ts_sig_reg_bit(ts_sig_reg_bit), .dl_bit_in(dl_bit_in),
    .dl_bit_take(dl_bit_take), .tx_line_out(tx_line_out));
  e1osp_backplane u_e1osp_backplane (.pclk(pclk), .lvl(lvl), .tx_serial_in(ser),
    .tx_fraction_data_in(frac), .tx_signaling_in(sig), .tx_overhead_in(ovh));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t %s got %b want %b", $time, m, got, exp);
    end
  endtask : chk_bit

  // Entered just after a rising edge; leaves one idle edge after the answering edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No wait limit here: the watchdog ends a hung transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb

  // Program, set pins, align a frame, then look at one outbound bit off cycles later
  task automatic run(input logic [3:0] lnk, input logic [7:0] ctl, input logic [4:0] lv,
                     input logic dl, input logic de, input int off, input logic exp,
                     input logic exp_take);
    apb(1'b1, LINK_A, {28'h0, lnk});
    apb(1'b1, CTRL_A, {24'h0, ctl});
    lvl <= lv[3:0];
    ts_sig_reg_bit <= lv[4];
    dl_bit_in <= dl;
    de_active <= de;
    frame_sync <= 1'b1;
    @(posedge pclk);
    frame_sync <= 1'b0;
    repeat (off) @(posedge pclk);
    #1;
    chk_bit(tx_line_out, exp, "line bit");
    chk_bit(dl_bit_take, exp_take, "link take");
    @(posedge pclk);
  endtask : run

  task automatic t_reset;
    apb(1'b0, LINK_A, 32'h0);
    chk_word(rd, 32'h0, "link select reset");
    apb(1'b0, CTRL_A, 32'h0);
    chk_word(rd, 32'h0, "control reset");
    apb(1'b0, 16'h0600, 32'h0);
    chk_bit(err, 1'b1, "unmapped error");
  endtask : t_reset

  task automatic t_sa4_link;
    run(4'h0, 8'h01, 5'h00, 1'b0, 1'b0, 260, 1'b1, 1'b0);
    run(4'h8, 8'h01, 5'h01, 1'b0, 1'b0, 260, 1'b0, 1'b1);
    run(4'h8, 8'h00, 5'h00, 1'b1, 1'b0, 260, 1'b0, 1'b0);
  endtask : t_sa4_link

  task automatic t_sa4_reg;
    run(4'h8, 8'h05, 5'h01, 1'b1, 1'b0, 260, 1'b0, 1'b0);
    run(4'h8, 8'h0d, 5'h00, 1'b0, 1'b0, 260, 1'b1, 1'b0);
  endtask : t_sa4_reg

  task automatic t_codes;
    run(4'ha, 8'h01, 5'h00, 1'b0, 1'b0, 260, 1'b1, 1'b0);
    run(4'hb, 8'h01, 5'h00, 1'b0, 1'b0, 260, 1'b1, 1'b0);
    run(4'h9, 8'h01, 5'h00, 1'b0, 1'b0, 260, 1'b0, 1'b1);
    // Unused code written on purpose; must behave as the default
    run(4'hd, 8'h01, 5'h00, 1'b0, 1'b0, 260, 1'b0, 1'b1);
    apb(1'b0, LINK_A, 32'h0);
    chk_word(rd, 32'h0000000d, "unused code readback");
  endtask : t_codes

  task automatic t_ts16;
    run(4'h0, 8'h40, 5'h04, 1'b0, 1'b0, 129, 1'b0, 1'b0);
    run(4'h2, 8'h40, 5'h04, 1'b0, 1'b0, 129, 1'b1, 1'b0);
    run(4'h1, 8'h20, 5'h08, 1'b0, 1'b0, 129, 1'b1, 1'b0);
    run(4'h3, 8'h10, 5'h10, 1'b0, 1'b0, 129, 1'b1, 1'b0);
    run(4'h1, 8'h30, 5'h04, 1'b0, 1'b0, 129, 1'b1, 1'b0);
    run(4'h1, 8'h00, 5'h1e, 1'b0, 1'b0, 129, 1'b0, 1'b0);
  endtask : t_ts16

  task automatic t_de;
    run(4'h0, 8'h80, 5'h04, 1'b0, 1'b1, 9, 1'b0, 1'b0);
    run(4'h4, 8'h80, 5'h04, 1'b0, 1'b1, 9, 1'b1, 1'b0);
    run(4'h4, 8'h00, 5'h1e, 1'b0, 1'b1, 9, 1'b0, 1'b0);
  endtask : t_de

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // About 3300 cycles are needed; the limit leaves wide margin
  initial begin
    #(40 * 20000);
    fail_count++;
    finish_test;
  end

  initial begin
    {presetn, psel, penable, pwrite, frame_sync, de_active, ts_sig_reg_bit, dl_bit_in} = 8'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    lvl = 4'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_sa4_link;
    t_sa4_reg;
    t_codes;
    t_ts16;
    t_de;
    finish_test;
  end
endmodule : tb_e1_tx_overhead_source_select
